//--- bench/ack_term_sva.sv
// Purpose: Checker on the bus between the processor end and external end
// Assumes: Termination pins active low, one clock domain
// Notes:   Instantiated beside the interface in the bench top
`timescale 1ns/1ns
module ack_term_sva
  import ack_term_pkg::*;
#(
  parameter int TIMEOUT = 8
)
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        start_n,
  input wire logic        busy_n,
  input wire logic        read,
  input wire logic [1:0]  transfer_type,
  input wire logic [2:0]  transfer_modifier,
  input wire logic [31:0] addr,
  input wire logic        transfer_ack_n,
  input wire logic        transfer_error_ack_n,
  input wire logic        autovector_req_n
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Cycles a started access waits unanswered
  // ****************************************
  int wait_reg;
  int wait_next;
  // Clears on any termination or when idle
  always_comb begin
    wait_next = wait_reg + 1;
    if (busy_n || !transfer_ack_n || !transfer_error_ack_n) begin
      wait_next = 0;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 0;
    end else begin
      wait_reg <= wait_next;
    end
  end
  property p_iack_read;
    !start_n && transfer_type == TT_ACK && addr == ADDR_IACK |-> read;
  endproperty
  a_iack_read: assert property (p_iack_read)
    else $error("acknowledge cycle not a read");
  property p_ack_addr;
    !busy_n && transfer_type == TT_ACK
      |-> addr == ADDR_IACK || addr == ADDR_BREAKPOINT_INSTRUCTION;
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("acknowledge cycle with bad address");
  property p_breakpoint_instruction_tm;
    !busy_n && transfer_type == TT_ACK && addr == ADDR_BREAKPOINT_INSTRUCTION
      |-> transfer_modifier == TM_BREAKPOINT_INSTRUCTION;
  endproperty
  a_breakpoint_instruction_tm: assert property (p_breakpoint_instruction_tm)
    else $error("breakpoint cycle modifier not zero");
  property p_autovector_req_with_ack;
    !autovector_req_n |-> !transfer_ack_n;
  endproperty
  a_autovector_req_with_ack: assert property (p_autovector_req_with_ack)
    else $error("autovector request without acknowledge");
  property p_pair_release;
    !transfer_error_ack_n |=> transfer_ack_n && transfer_error_ack_n;
  endproperty
  a_pair_release: assert property (p_pair_release)
    else $error("termination pins not released together");
  property p_ack_ends;
    !transfer_ack_n && transfer_error_ack_n && transfer_type == TT_ACK
      |-> ##[1:6] busy_n;
  endproperty
  a_ack_ends: assert property (p_ack_ends)
    else $error("acknowledged cycle did not complete");
  property p_error_ends;
    transfer_ack_n && !transfer_error_ack_n |-> ##[1:6] busy_n;
  endproperty
  a_error_ends: assert property (p_error_ends)
    else $error("bus error did not end the access");
  property p_retry;
    !transfer_ack_n && !transfer_error_ack_n && transfer_type == TT_ACK
      |-> ##[1:8] !start_n;
  endproperty
  a_retry: assert property (p_retry)
    else $error("acknowledge cycle not retried");
  property p_timeout;
    wait_reg <= TIMEOUT + 4;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("unanswered cycle not ended by error");
endmodule

//--- bench/bus_ack_and_error_termination_tb_top.sv
// Purpose: Bench joining both ends over the acknowledge bus
// Assumes: External end answers while answer_valid_i is high
// Notes:   Bus timeout shortened to 8 cycles
`timescale 1ns/1ns
module bus_ack_and_error_termination_tb_top;
  import ack_term_pkg::*;
  // ****************************************
  // Stimulus, outputs and records
  // ****************************************
  logic        clock_i, rst_i, req_valid, misal, pref, forced, wt, dirty;
  logic        used, flush, ans_valid, use_av;
  acc_e        kind;
  term_e       ans_kind;
  logic [31:0] req_addr, wdata, rdata;
  logic [2:0]  irq_n;
  logic [1:0]  beat;
  logic [7:0]  vec, vec_o, r_vec;
  logic        busy, done, vv, ill, ae, lv, ld, seen, to, r_rd;
  logic [2:0]  r_tm;
  logic [1:0]  r_tt;
  logic [31:0] r_addr;
  int          errors, comparisons, cyc, r_vv, r_ill, r_ae, r_to, r_st, r_nt;
  int          r_sn;
  ack_bus_if bus (.clock_i(clock_i), .rst_i(rst_i));
  ack_cpu_end u_ack_cpu_end (.bus(bus), .req_valid_i(req_valid),
    .req_kind_i(kind), .req_addr_i(req_addr), .req_wdata_i(wdata),
    .irq_level_in_n_i(irq_n), .req_beat_i(beat), .req_misaligned_i(misal),
    .req_prefetch_i(pref), .req_forced_push_i(forced),
    .req_write_through_i(wt), .req_dirty_i(dirty), .prefetch_used_i(used),
    .prefetch_flush_i(flush), .busy_o(busy), .done_o(done),
    .vector_o(vec_o), .vector_valid_o(vv), .illegal_instr_o(ill),
    .access_error_o(ae), .line_valid_o(lv), .line_dirty_o(ld));
  ack_ext_end #(.TIMEOUT(8)) u_ack_ext_end (.bus(bus),
    .answer_valid_i(ans_valid), .answer_kind_i(ans_kind),
    .use_autovector_i(use_av), .vector_i(vec), .rdata_i(rdata),
    .cycle_seen_o(seen), .timed_out_o(to));
  ack_term_sva #(.TIMEOUT(8)) u_ack_term_sva (.clock_i(clock_i),
    .rst_i(rst_i), .start_n(bus.start_n), .busy_n(bus.busy_n),
    .read(bus.read), .transfer_type(bus.transfer_type),
    .transfer_modifier(bus.transfer_modifier), .addr(bus.addr),
    .transfer_ack_n(bus.transfer_ack_n),
    .transfer_error_ack_n(bus.transfer_error_ack_n),
    .autovector_req_n(bus.autovector_req_n));
  // Clock at 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Cut a hang short
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  function automatic logic [7:0] auto_vec(input int l);
    auto_vec = 8'(l) + VEC_AUTO_OFS;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // One access; answer switches to a2 after sw terminations
  task automatic acc(input string nm, input acc_e k, input term_e a1,
                     input int sw, input term_e a2, input logic en);
    int n;
    n = 0;
    r_vv = 0; r_ill = 0; r_ae = 0; r_to = 0; r_st = 0; r_nt = 0; r_sn = 0;
    kind <= k;
    ans_kind <= a1;
    ans_valid <= en;
    req_valid <= 1'b1;
    @(posedge clock_i);
    req_valid <= 1'b0;
    while (n < 300) begin
      @(negedge clock_i);
      if (bus.start_n === 1'b0) begin
        r_st++;
        r_tm = bus.transfer_modifier;
        r_addr = bus.addr;
        r_tt = bus.transfer_type;
        r_rd = bus.read;
      end
      if (!bus.transfer_ack_n || !bus.transfer_error_ack_n) r_nt++;
      if (vv === 1'b1) begin
        r_vv++;
        r_vec = vec_o;
      end
      r_ill += int'(ill === 1'b1);
      r_ae += int'(ae === 1'b1);
      r_to += int'(to === 1'b1);
      r_sn += int'(seen === 1'b1);
      if (done === 1'b1 && n < 296) n = 296;
      n++;
      @(posedge clock_i);
      if (r_nt == sw) ans_kind <= a2;
    end
    ans_valid <= 1'b0;
    $display("Test %s done", nm);
  endtask
  // Held fetch is used or flushed, then error pulses are counted
  task automatic use_pf(input logic u);
    used <= u;
    flush <= !u;
    @(posedge clock_i);
    used <= 1'b0;
    flush <= 1'b0;
    r_ae = 0;
    repeat (6) begin
      @(negedge clock_i);
      r_ae += int'(ae === 1'b1);
    end
    @(posedge clock_i);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    term_e bk[2];
    bk = '{TERM_NORMAL, TERM_ERROR};
    rst_i = 1'b1; req_valid = 1'b0; kind = ACC_READ; ans_kind = TERM_WAIT;
    {misal, pref, forced, wt, dirty, used, flush, ans_valid, use_av} = '0;
    req_addr = 32'h0; wdata = 32'h0; rdata = 32'h0; irq_n = 3'h7;
    beat = 2'h0; vec = 8'h0; errors = 0; comparisons = 0; cyc = 0;
    void'($urandom(84738));
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int l = 1; l < 8; l++) begin
      irq_n <= ~3'(l);
      vec <= 8'($urandom_range(255, 64));
      rdata <= $urandom();
      use_av <= 1'b0;
      repeat (3) @(posedge clock_i);
      acc("vectored", ACC_IACK, TERM_NORMAL, 99, TERM_NORMAL, 1'b1);
      chk("iack_type", TT_ACK, r_tt);
      chk("iack_read", 1, r_rd);
      chk("iack_addr", ADDR_IACK, r_addr);
      chk("iack_level", l, r_tm);
      chk("vector", vec, r_vec);
      use_av <= 1'b1;
      acc("autovector", ACC_IACK, TERM_NORMAL, 99, TERM_NORMAL, 1'b1);
      chk("auto_vector", auto_vec(l), r_vec);
    end
    acc("spurious", ACC_IACK, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("spurious", VEC_SPURIOUS, r_vec);
    use_av <= 1'b0;
    acc("retry", ACC_IACK, TERM_RETRY, 1, TERM_NORMAL, 1'b1);
    chk("retry_starts", 2, r_st);
    chk("retry_vector", vec, r_vec);
    chk("retry_seen", 2, r_sn);
    foreach (bk[i]) begin
      acc("breakpoint", ACC_BREAKPOINT_INSTRUCTION, bk[i], 99, bk[i], 1'b1);
      chk("breakpoint_instruction_addr", ADDR_BREAKPOINT_INSTRUCTION, r_addr);
      chk("breakpoint_instruction_tm", TM_BREAKPOINT_INSTRUCTION, r_tm);
      chk("breakpoint_instruction_illegal", 1, r_ill);
    end
    req_addr <= $urandom() & 32'hFFFFFFF0;
    acc("timeout", ACC_READ, TERM_NORMAL, 99, TERM_NORMAL, 1'b0);
    chk("timed_out", 1, r_to);
    chk("timeout_error", 1, r_ae);
    wdata <= $urandom();
    acc("write_error", ACC_WRITE, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("write_error", 1, r_ae);
    chk("idle_busy", 0, busy);
    pref <= 1'b1;
    acc("prefetch", ACC_READ, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("pf_held", 0, r_ae);
    use_pf(1'b1);
    chk("pf_used", 1, r_ae);
    acc("prefetch", ACC_READ, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    use_pf(1'b0);
    chk("pf_flushed", 0, r_ae);
    pref <= 1'b0;
    acc("fill_beat3", ACC_LINE_FILL, TERM_NORMAL, 2, TERM_ERROR, 1'b1);
    chk("fill_beats", 3, r_nt);
    chk("fill_unwanted", 0, r_ae);
    chk("fill_invalid", 0, lv);
    beat <= 2'h2;
    acc("fill_wanted", ACC_LINE_FILL, TERM_NORMAL, 2, TERM_ERROR, 1'b1);
    chk("fill_wanted", 1, r_ae);
    misal <= 1'b1;
    beat <= 2'h0;
    acc("misaligned", ACC_LINE_FILL, TERM_NORMAL, 1, TERM_ERROR, 1'b1);
    chk("misaligned", 1, r_ae);
    misal <= 1'b0;
    dirty <= 1'b1;
    acc("dirty_fill", ACC_LINE_FILL, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("restore_valid", 1, lv);
    chk("restore_dirty", 1, ld);
    dirty <= 1'b0;
    forced <= 1'b1;
    acc("forced_push", ACC_PUSH, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("forced_push", 0, lv);
    forced <= 1'b0;
    acc("replace_push", ACC_PUSH, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("replace_push", 1, lv);
    wt <= 1'b1;
    acc("write_thru", ACC_WRITE, TERM_ERROR, 99, TERM_ERROR, 1'b1);
    chk("write_thru", 1, lv);
    print_verdict();
  end
  task automatic print_verdict();
    $display("Comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
endmodule

//--- core/ack_cpu_end.sv
// Purpose: Processor end: acknowledge cycles and abnormal termination
// Assumes: Requests come from core logic on the same clock
// Notes:   Termination pins pass two flops before decoding
// Function
// RULE1: interrupt acknowledge is read, type 3
// RULE2: interrupt acknowledge address is all ones
// RULE3: modifier carries inverted interrupt level pins
// RULE4: vectoring interrupter returns vector with ack
// RULE5: autovector request only counts with ack
// RULE6: autovector is level plus 24
// RULE7: error alone gives spurious vector 24
// RULE8: ack plus error retries the acknowledge
// RULE9: breakpoint cycle: type 3, address 0, modifier 0
// RULE10: breakpoint end raises illegal instruction
// RULE11: external timeout asserts error ack
// RULE12: ack and error change on one edge
// RULE13: decode termination pair every sampled edge
// RULE14: bus error aborts access and line
// RULE15: prefetch error deferred until used
// RULE16: later line beat error only if requested
// RULE17: misaligned span error is immediate
// RULE18: write or requested read error immediate
// RULE19: fill target invalid, stays invalid on error
// RULE20: replacement read error restores dirty line
// RULE21: push error: valid after replace, invalid forced
// RULE22: write-through line stays valid on error
// RULE23: plain ack latches vector from low byte
`timescale 1ns/1ns
module ack_cpu_end
  import ack_term_pkg::*;
(
  ack_bus_if.cpu                 bus,
  input  wire logic              req_valid_i,   // One-cycle access request
  input  wire ack_term_pkg::acc_e req_kind_i,
  input  wire logic [31:0]       req_addr_i,
  input  wire logic [31:0]       req_wdata_i,
  input  wire logic [2:0]        irq_level_in_n_i, // Active-low level pins
  input  wire logic [1:0]        req_beat_i,    // Beat the core wants
  input  wire logic              req_misaligned_i,
  input  wire logic              req_prefetch_i,
  input  wire logic              req_forced_push_i,
  input  wire logic              req_write_through_i,
  input  wire logic              req_dirty_i,
  input  wire logic              prefetch_used_i,  // Held fetch now used
  input  wire logic              prefetch_flush_i, // Branch or task switch
  output logic                   busy_o,
  output logic                   done_o,
  output logic [7:0]             vector_o,
  output logic                   vector_valid_o,
  output logic                   illegal_instr_o,
  output logic                   access_error_o,
  output logic                   line_valid_o,
  output logic                   line_dirty_o
);
  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} state_e;
  // Sequencer state, registered as one word
  typedef struct packed {
    state_e      state;
    acc_e        kind;
    logic [1:0]  beat, want;    // Beat in progress, beat the core wants
    logic [31:0] addr, wdata;
    logic [2:0]  tm;
    logic [7:0]  vec;
    logic        mis, pf, fp;   // Misaligned, prefetch, forced push
    logic        wt, dirty;     // Write-through page, dirty victim line
    logic        start_n, busy_n, busy, done;
    logic        vv, ill, aerr; // One-cycle result pulses
    logic        held, lv, ld;  // Held fetch error, line valid and dirty
  } seq_s;
  // Register values held in reset: idle, pins released
  localparam seq_s SEQ_RESET = '{state: S_IDLE, kind: ACC_READ,
                                 start_n: 1'b1, busy_n: 1'b1, default: '0};
  wire logic clock_i = bus.clock_i;
  wire logic rst_i = bus.rst_i;
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] ipl_meta_reg, ipl_sync_reg;
  logic [2:0] ack_meta_reg, ack_sync_reg;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ipl_meta_reg <= 3'h7;
      ipl_sync_reg <= 3'h7;
      ack_meta_reg <= 3'h7;
      ack_sync_reg <= 3'h7;
    end else begin
      ipl_meta_reg <= irq_level_in_n_i;
      ipl_sync_reg <= ipl_meta_reg;
      ack_meta_reg <= {bus.transfer_ack_n, bus.transfer_error_ack_n,
                       bus.autovector_req_n};
      ack_sync_reg <= ack_meta_reg;
    end
  end
  // ****************************************
  // Access sequencer
  // ****************************************
  seq_s  seq_reg, seq_next;
  term_e term;
  logic  line_acc;

  // Next-state and outcome logic
  always_comb begin
    term = decode_term(ack_sync_reg[2], ack_sync_reg[1]); // RULE13
    line_acc = (seq_reg.kind == ACC_LINE_FILL) || (seq_reg.kind == ACC_PUSH);
    seq_next = seq_reg;
    seq_next.start_n = 1'b1;
    seq_next.done = 1'b0;
    seq_next.vv = 1'b0;
    seq_next.ill = 1'b0;
    seq_next.aerr = 1'b0;
    // Deferred prefetch error: raise on use, drop on flush
    if (seq_reg.held && prefetch_flush_i) begin
      seq_next.held = 1'b0;                                    // RULE15
    end else if (seq_reg.held && prefetch_used_i) begin
      seq_next.held = 1'b0;
      seq_next.aerr = 1'b1;                                    // RULE15
    end
    case (seq_reg.state)
      S_IDLE: begin
        if (req_valid_i) begin
          seq_next.kind = req_kind_i;
          seq_next.beat = 2'h0;
          seq_next.want = req_beat_i;
          seq_next.mis = req_misaligned_i;
          seq_next.pf = req_prefetch_i;
          seq_next.fp = req_forced_push_i;
          seq_next.wt = req_write_through_i;
          seq_next.dirty = req_dirty_i;
          seq_next.wdata = req_wdata_i;
          seq_next.addr = req_addr_i;
          seq_next.tm = 3'h0;
          seq_next.start_n = 1'b0;
          seq_next.busy_n = 1'b0;
          seq_next.state = S_START;
          case (req_kind_i)
            ACC_IACK: begin
              seq_next.addr = ADDR_IACK;                       // RULE2
              seq_next.tm = ~ipl_sync_reg;                     // RULE3
            end
            ACC_BREAKPOINT_INSTRUCTION: begin
              seq_next.addr = ADDR_BREAKPOINT_INSTRUCTION;                       // RULE9
              seq_next.tm = TM_BREAKPOINT_INSTRUCTION;                           // RULE9
            end
            ACC_LINE_FILL: seq_next.lv = 1'b0;                 // RULE19
            ACC_WRITE: begin
              if (req_write_through_i) begin
                seq_next.lv = 1'b1;                            // RULE22
              end
            end
            default: begin
            end
          endcase
        end
      end
      S_START: begin
        seq_next.state = S_WAIT;
      end
      S_WAIT: begin
        case (term)
          TERM_NORMAL: begin
            if (seq_reg.kind == ACC_IACK) begin
              seq_next.vec = VEC_AUTO_OFS + {5'h0, seq_reg.tm};  // RULE6
              if (ack_sync_reg[0]) begin                         // RULE5
                seq_next.vec = bus.rdata[7:0];                   // RULE23
              end
              seq_next.vv = 1'b1;
            end else if (seq_reg.kind == ACC_BREAKPOINT_INSTRUCTION) begin
              seq_next.ill = 1'b1;                             // RULE10
            end
            if (line_acc && seq_reg.beat != LINE_BEATS_M1) begin
              seq_next.beat = seq_reg.beat + 2'h1;
              seq_next.addr = seq_reg.addr + 32'h4;
            end else begin
              if (seq_reg.kind == ACC_LINE_FILL) begin
                seq_next.lv = 1'b1;
                seq_next.ld = 1'b0;
              end
              if (seq_reg.kind == ACC_PUSH) begin
                seq_next.ld = 1'b0;
                seq_next.lv = ~seq_reg.fp;
              end
              seq_next.busy_n = 1'b1;
              seq_next.done = 1'b1;
              seq_next.state = S_IDLE;
            end
          end
          TERM_RETRY: begin
            if (line_acc && seq_reg.beat != 2'h0) begin
              term = TERM_ERROR;
            end else begin
              seq_next.start_n = 1'b0;                         // RULE8
              seq_next.state = S_START;
            end
          end
          default: begin
          end
        endcase
        if (term == TERM_ERROR) begin
          seq_next.busy_n = 1'b1;                              // RULE14
          seq_next.done = 1'b1;
          seq_next.state = S_IDLE;
          case (seq_reg.kind)
            ACC_IACK: begin
              seq_next.vec = VEC_SPURIOUS;                     // RULE7
              seq_next.vv = 1'b1;
            end
            ACC_BREAKPOINT_INSTRUCTION: seq_next.ill = 1'b1;                     // RULE10
            ACC_WRITE: begin
              seq_next.aerr = 1'b1;                            // RULE18
              if (seq_reg.wt) begin
                seq_next.lv = 1'b1;                            // RULE22
              end
            end
            ACC_PUSH: begin
              seq_next.aerr = 1'b1;                            // RULE18
              seq_next.lv = ~seq_reg.fp;                       // RULE21
              seq_next.ld = 1'b0;
            end
            ACC_LINE_FILL: begin
              seq_next.lv = seq_reg.dirty;                     // RULE19
              seq_next.ld = seq_reg.dirty;                     // RULE20
              if (seq_reg.pf) begin
                seq_next.held = 1'b1;                          // RULE15
              end else if (seq_reg.mis &&
                           seq_reg.beat <= seq_reg.want + 2'h1) begin
                seq_next.aerr = 1'b1;                          // RULE17
              end else if (seq_reg.beat == seq_reg.want) begin
                seq_next.aerr = 1'b1;                          // RULE16
              end
            end
            default: begin
              if (seq_reg.pf) begin
                seq_next.held = 1'b1;                          // RULE15
              end else begin
                seq_next.aerr = 1'b1;                          // RULE18
              end
            end
          endcase
        end
      end
      default: seq_next.state = S_IDLE;
    endcase
    seq_next.busy = ~seq_next.busy_n;
  end

  // Sequencer register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      seq_reg <= SEQ_RESET;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Bus and status outputs
  assign bus.start_n = seq_reg.start_n;
  assign bus.busy_n = seq_reg.busy_n;
  assign bus.read = (seq_reg.kind != ACC_WRITE) && (seq_reg.kind != ACC_PUSH);
  assign bus.transfer_type = (seq_reg.kind == ACC_IACK) ||
                             (seq_reg.kind == ACC_BREAKPOINT_INSTRUCTION) ? TT_ACK   // RULE1
                                                        : TT_NORMAL;
  assign bus.transfer_modifier = seq_reg.tm;
  assign bus.addr = seq_reg.addr;
  assign bus.wdata = seq_reg.wdata;
  assign busy_o = seq_reg.busy;
  assign done_o = seq_reg.done;
  assign vector_o = seq_reg.vec;
  assign vector_valid_o = seq_reg.vv;
  assign illegal_instr_o = seq_reg.ill;
  assign access_error_o = seq_reg.aerr;
  assign line_valid_o = seq_reg.lv;
  assign line_dirty_o = seq_reg.ld;
endmodule

//--- core/ack_ext_end.sv
// Purpose: External end: interrupter, slave and bus-timeout monitor
// Assumes: User side chooses how each cycle is answered
// Notes:   Ack and error pins are registered on one edge; retry asserts both together
`timescale 1ns/1ns
module ack_ext_end
  import ack_term_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYCLES
)
(
  ack_bus_if.ext                 bus,
  input  wire logic              answer_valid_i, // Slave answers this cycle
  input  wire ack_term_pkg::term_e answer_kind_i,
  input  wire logic              use_autovector_i,
  input  wire logic [7:0]        vector_i,
  input  wire logic [31:0]       rdata_i,
  output logic                   cycle_seen_o,
  output logic                   timed_out_o
);
  if (TIMEOUT < 2) begin : g_timeout_check
    $error("TIMEOUT too small");
  end
  wire logic clock_i = bus.clock_i;
  wire logic rst_i = bus.rst_i;
  logic        ta_n_reg, ta_n_next, tea_n_reg, tea_n_next;
  logic        av_n_reg, av_n_next, seen_reg, seen_next, to_reg, to_next;
  logic [31:0] rd_reg, rd_next, cnt_reg, cnt_next;
  logic        ack_cyc;
  logic [1:0]  hold_reg, hold_next; // Processor sees answers two flops late

  // Answer and timeout logic
  always_comb begin
    ack_cyc = (bus.transfer_type == TT_ACK) && (bus.addr == ADDR_IACK);
    ta_n_next = 1'b1;
    tea_n_next = 1'b1;
    av_n_next = 1'b1;
    rd_next = rd_reg;
    seen_next = 1'b0;
    to_next = 1'b0;
    hold_next = (hold_reg != 2'h0) ? hold_reg - 2'h1 : 2'h0;
    cnt_next = bus.busy_n ? 32'h0 : cnt_reg + 32'h1;
    if (!bus.start_n) begin
      seen_next = 1'b1;
      cnt_next = 32'h0;
    end
    if (!bus.busy_n && hold_reg == 2'h0) begin
      if (answer_valid_i) begin
        hold_next = TERM_GAP;
        // RULE12
        ta_n_next = ~((answer_kind_i == TERM_NORMAL) ||
                      (answer_kind_i == TERM_RETRY));
        tea_n_next = ~((answer_kind_i == TERM_ERROR) ||
                       (answer_kind_i == TERM_RETRY));
        if (ack_cyc && answer_kind_i == TERM_NORMAL) begin
          av_n_next = ~use_autovector_i;                       // RULE5
          rd_next = {24'h0, vector_i};                         // RULE4
        end else begin
          rd_next = rdata_i;
        end
      end else if (cnt_reg >= 32'(TIMEOUT)) begin
        tea_n_next = 1'b0;                                     // RULE11
        to_next = 1'b1;
        hold_next = TERM_GAP;
      end
    end
  end

  // Registered pins
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ta_n_reg <= 1'b1;
      tea_n_reg <= 1'b1;
      av_n_reg <= 1'b1;
      rd_reg <= 32'h0;
      seen_reg <= 1'b0;
      to_reg <= 1'b0;
      cnt_reg <= 32'h0;
      hold_reg <= 2'h0;
    end else begin
      ta_n_reg <= ta_n_next;
      tea_n_reg <= tea_n_next;
      av_n_reg <= av_n_next;
      rd_reg <= rd_next;
      seen_reg <= seen_next;
      to_reg <= to_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  assign bus.transfer_ack_n = ta_n_reg;
  assign bus.transfer_error_ack_n = tea_n_reg;
  assign bus.autovector_req_n = av_n_reg;
  assign bus.rdata = rd_reg;
  assign cycle_seen_o = seen_reg;
  assign timed_out_o = to_reg;
endmodule

//--- inc/ack_bus_if.sv
// Purpose: Bus wires between the processor end and external logic
// Assumes: Termination pins are active low
// Notes:   No clocking block; both ends are design modules
`timescale 1ns/1ns
interface ack_bus_if (
  input wire logic clock_i,
  input wire logic rst_i
);
  logic        start_n;            // Cycle start, active low, one cycle
  logic        busy_n;             // Cycle in progress, active low
  logic        read;               // High for a read transfer
  logic [1:0]  transfer_type;      // {transfer_type_hi, transfer_type_lo}
  logic [2:0]  transfer_modifier;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        transfer_ack_n;
  logic        transfer_error_ack_n;
  logic        autovector_req_n;
  modport cpu (
    input  clock_i, rst_i, rdata, transfer_ack_n, transfer_error_ack_n,
           autovector_req_n,
    output start_n, busy_n, read, transfer_type, transfer_modifier, addr,
           wdata
  );
  modport ext (
    input  clock_i, rst_i, start_n, busy_n, read, transfer_type,
           transfer_modifier, addr, wdata,
    output rdata, transfer_ack_n, transfer_error_ack_n, autovector_req_n
  );
endinterface

//--- inc/ack_term_pkg.sv
// Purpose: Shared constants for acknowledge cycles and bus termination
// Assumes: One bus clock, active-low termination pins sampled on rise
// Notes:   Used by the processor end and the external-logic end
package ack_term_pkg;
  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [1:0]  TT_NORMAL    = 2'h0;
  localparam logic [1:0]  TT_ACK       = 2'h3;
  localparam logic [31:0] ADDR_IACK    = 32'hFFFFFFFF;
  localparam logic [31:0] ADDR_BREAKPOINT_INSTRUCTION    = 32'h00000000;
  localparam logic [2:0]  TM_BREAKPOINT_INSTRUCTION      = 3'h0;
  localparam logic [7:0]  VEC_AUTO_OFS = 8'h18;
  localparam logic [7:0]  VEC_SPURIOUS = 8'h18;
  localparam logic [1:0]  LINE_BEATS_M1 = 2'h3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_HZ        = 10000000;
  localparam int TIMEOUT_NS      = 10000;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_NS / (1000000000 / CLOCK_HZ);
  localparam logic [1:0] TERM_GAP = 2'h3; // Quiet cycles after an answer
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    TERM_WAIT,
    TERM_NORMAL,
    TERM_ERROR,
    TERM_RETRY
  } term_e;
  typedef enum logic [2:0] {
    ACC_IACK,
    ACC_BREAKPOINT_INSTRUCTION,
    ACC_READ,
    ACC_WRITE,
    ACC_LINE_FILL,
    ACC_PUSH
  } acc_e;
  // Decode of active-low termination pair
  function automatic term_e decode_term(input logic ta_n, input logic tea_n);
    case ({ta_n, tea_n})
      2'b10:   decode_term = TERM_ERROR;
      2'b00:   decode_term = TERM_RETRY;
      2'b01:   decode_term = TERM_NORMAL;
      default: decode_term = TERM_WAIT;
    endcase
  endfunction
endpackage
